// ==== inc/uoe_pkg.sv ====
package uoe_pkg;
   // ======================================================
   // Sizes
   localparam int EP_NUM = 4;
   localparam int EP_W = 2;
   localparam int FIFO_DEPTH = 32;
   localparam int IDX_W = 5;
   localparam int PTR_W = 6;
   localparam int ADDR_W = 10;
   // ======================================================
   // Register offsets
   localparam logic [9:0] ADDR_EP_SELECT = 10'h330;
   localparam logic [9:0] ADDR_OUT_CSR = 10'h332;
   localparam logic [9:0] ADDR_IN_MAX_PACKET_SIZE = 10'h333;
   localparam logic [9:0] ADDR_OUT_MAX_PACKET_SIZE = 10'h334;
   localparam logic [9:0] ADDR_RX_COUNT = 10'h335;
   localparam logic [9:0] ADDR_FIFO_DATA = 10'h33B;
   localparam logic [9:0] ADDR_INT_STATUS = 10'h340;
   localparam logic [9:0] ADDR_INT_CLEAR = 10'h341;
   localparam logic [9:0] ADDR_INT_ENABLE = 10'h342;
   // ======================================================
   // Control and status field positions
   localparam int CSR_READY = 0;
   localparam int CSR_OVERRUN = 1;
   localparam int CSR_SEND_STALL = 2;
   localparam int CSR_ISO = 3;
   localparam int CSR_FORCE_STALL = 4;
   localparam int CSR_DATA_ERR = 5;
   localparam int CSR_FLUSH = 6;
   localparam int CSR_AUTO_CLEAR = 7;
   localparam int INT_ERR_BASE = 4;
   // ======================================================
   // Reset values
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [1:0] RESET_EP = 2'h0;
   // ======================================================
   // Types
   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_RECV = 2'b01,
      RX_DROP = 2'b10
   } uoe_rx_state_t;
   typedef struct packed {
      logic [9:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } uoe_cpu_t;
   typedef struct packed {
      logic start;
      logic valid;
      logic [7:0] data;
      logic good;
      logic bad;
      logic [1:0] ep;
   } uoe_rx_t;
endpackage

// ==== core/uoe_byte_fifo.sv ====
`timescale 1ns/1ns
module uoe_byte_fifo (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic pushValid,
   input wire logic [7:0] pushData,
   output logic pushReady,
   input wire logic popReq,
   output logic [7:0] headData,
   output logic empty
);
   logic [7:0] mem [uoe_pkg::FIFO_DEPTH];
   logic [uoe_pkg::PTR_W-1:0] wPtr;
   logic [uoe_pkg::PTR_W-1:0] rPtr;
   logic [uoe_pkg::PTR_W-1:0] level;
   logic doPush;
   logic doPop;

   assign level = wPtr - rPtr;
   assign empty = (level == '0);
   assign pushReady = (level != uoe_pkg::PTR_W'(uoe_pkg::FIFO_DEPTH));
   assign headData = mem[rPtr[uoe_pkg::IDX_W-1:0]];
   assign doPush = pushValid && pushReady;
   assign doPop = popReq && !empty;

   always_ff @(posedge ref_clk) begin
      if (doPush) begin
         mem[wPtr[uoe_pkg::IDX_W-1:0]] <= pushData;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         wPtr <= '0;
         rPtr <= '0;
      end else begin
         if (doPush) begin
            wPtr <= wPtr + uoe_pkg::PTR_W'(1);
         end
         if (doPop) begin
            rPtr <= rPtr + uoe_pkg::PTR_W'(1);
         end
      end
   end

   property p_push_one;
      @(posedge ref_clk) disable iff (!reset_n)
         (doPush && !doPop) |=> (level == $past(level) + uoe_pkg::PTR_W'(1));
   endproperty
   a_push_one: assert property (p_push_one) else $error("push did not add one byte");
endmodule

// ==== core/uoe_out_ep_ctrl.sv ====
`timescale 1ns/1ns
module uoe_out_ep_ctrl (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire uoe_pkg::uoe_cpu_t cpuReq,
   output logic [7:0] cpuRdData,
   input wire uoe_pkg::uoe_rx_t rxIn,
   output logic [3:0] rxStall,
   output logic [3:0] rxRoom,
   input wire logic txPop,
   input wire logic [1:0] txEp,
   output logic [7:0] txData,
   output logic [3:0] txEmpty,
   output logic irq
);
   // ======================================================
   // Register decode
   function automatic logic hit(input logic [9:0] a, input logic [9:0] off);
      hit = (a == off);
   endfunction

   logic wrSel, wrCsr, wrInMaxp, wrOutMaxp, wrFifo, wrIntClr, wrIntEn, rdFifo;
   assign wrSel = cpuReq.wr && hit(cpuReq.addr, uoe_pkg::ADDR_EP_SELECT);
   assign wrCsr = cpuReq.wr && hit(cpuReq.addr, uoe_pkg::ADDR_OUT_CSR);
   assign wrInMaxp = cpuReq.wr && hit(cpuReq.addr, uoe_pkg::ADDR_IN_MAX_PACKET_SIZE);
   assign wrOutMaxp = cpuReq.wr && hit(cpuReq.addr, uoe_pkg::ADDR_OUT_MAX_PACKET_SIZE);
   assign wrFifo = cpuReq.wr && hit(cpuReq.addr, uoe_pkg::ADDR_FIFO_DATA);
   assign wrIntClr = cpuReq.wr && hit(cpuReq.addr, uoe_pkg::ADDR_INT_CLEAR);
   assign wrIntEn = cpuReq.wr && hit(cpuReq.addr, uoe_pkg::ADDR_INT_ENABLE);
   assign rdFifo = cpuReq.rd && hit(cpuReq.addr, uoe_pkg::ADDR_FIFO_DATA);

   logic [1:0] epSel;
   logic [7:0] inMaxp [4];
   logic [7:0] outMaxp [4];
   logic [3:0] sendStall, iso, autoClr, overrun, forceStall, dataErr;
   logic [1:0] pktCnt [4];
   logic [7:0] len0 [4];
   logic [7:0] len1 [4];
   logic [5:0] rPtr [4];
   logic [5:0] base [4];
   logic [5:0] wPtr [4];
   logic [7:0] rxMem [4][32];
   logic [3:0] fifoRd, autoHit, release_, commit, csrClr;
   logic [7:0] intStatus, intEnable, intSet;
   logic [7:0] txHead [4];
   logic [7:0] fifoByte;

   // ======================================================
   // Reception from the function control unit
   uoe_pkg::uoe_rx_state_t state;
   logic [1:0] curEp;
   logic [7:0] rxLen;
   logic [5:0] used;
   logic overSize, noSpace, takeByte, commitPulse, startOk;

   assign used = wPtr[curEp] - rPtr[curEp];
   assign overSize = (rxLen == outMaxp[curEp]);
   assign noSpace = ({2'b00, used} + rxLen) >= 8'(uoe_pkg::FIFO_DEPTH);
   assign takeByte = (state == uoe_pkg::RX_RECV) && rxIn.valid && !overSize && !noSpace;
   assign commitPulse = (state == uoe_pkg::RX_RECV) && rxIn.good;
   assign startOk = rxRoom[rxIn.ep] && !rxStall[rxIn.ep];

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= uoe_pkg::RX_IDLE;
         curEp <= uoe_pkg::RESET_EP;
         rxLen <= uoe_pkg::RESET_BYTE;
      end else if (rxIn.start) begin
         curEp <= rxIn.ep;
         rxLen <= uoe_pkg::RESET_BYTE;
         state <= startOk ? uoe_pkg::RX_RECV : uoe_pkg::RX_IDLE;
      end else begin
         case (state)
            uoe_pkg::RX_RECV: begin
               if (rxIn.good || rxIn.bad) begin
                  state <= uoe_pkg::RX_IDLE;
               end else if (rxIn.valid && (overSize || noSpace)) begin
                  // Oversize or no room: the whole packet is thrown away, since it is never committed.
                  state <= uoe_pkg::RX_DROP;
               end else if (takeByte) begin
                  rxLen <= rxLen + 8'h01;
               end
            end
            uoe_pkg::RX_DROP: begin
               if (rxIn.good || rxIn.bad) begin
                  state <= uoe_pkg::RX_IDLE;
               end
            end
            default: state <= uoe_pkg::RX_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (takeByte) begin
         rxMem[curEp][5'(wPtr[curEp] + rxLen[5:0])] <= rxIn.data;
      end
   end

   // ======================================================
   // Per endpoint packet bookkeeping and flags
   genvar e;
   generate
      for (e = 0; e < uoe_pkg::EP_NUM; e++) begin : g_ep
         logic selW;
         logic [5:0] headEnd;
         logic [7:0] unloaded;
         assign selW = wrCsr && (epSel == 2'(e));
         assign headEnd = base[e] + len0[e][5:0];
         assign unloaded = {2'b00, 6'(rPtr[e] - base[e])} + 8'h01;
         assign commit[e] = commitPulse && (curEp == 2'(e));
         assign fifoRd[e] = rdFifo && (epSel == 2'(e)) && (pktCnt[e] != 2'h0)
                            && (rPtr[e] != headEnd);
         assign autoHit[e] = autoClr[e] && fifoRd[e] && (outMaxp[e] != 8'h00)
                             && (unloaded == outMaxp[e]);
         // A zero written to ready and a flush both drop the head packet, so
         // a second packet becomes the head and ready stays set for it.
         assign csrClr[e] = selW && (!cpuReq.wdata[uoe_pkg::CSR_READY]
                            || cpuReq.wdata[uoe_pkg::CSR_FLUSH]);
         assign release_[e] = (pktCnt[e] != 2'h0) && (csrClr[e] || autoHit[e]);
         assign rxRoom[e] = (pktCnt[e] != 2'h2);
         assign rxStall[e] = sendStall[e] || forceStall[e];

         always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
               pktCnt[e] <= 2'h0;
               len0[e] <= uoe_pkg::RESET_BYTE;
               len1[e] <= uoe_pkg::RESET_BYTE;
            end else begin
               if (commit[e] && !release_[e]) begin
                  pktCnt[e] <= pktCnt[e] + 2'h1;
               end else if (release_[e] && !commit[e]) begin
                  pktCnt[e] <= pktCnt[e] - 2'h1;
               end
               if (commit[e] && (pktCnt[e] == (release_[e] ? 2'h1 : 2'h0))) begin
                  len0[e] <= rxLen;
               end else if (release_[e]) begin
                  len0[e] <= len1[e];
               end
               if (commit[e] && (pktCnt[e] == 2'h1) && !release_[e]) begin
                  len1[e] <= rxLen;
               end
            end
         end

         always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
               rPtr[e] <= '0;
               base[e] <= '0;
               wPtr[e] <= '0;
            end else begin
               if (release_[e]) begin
                  rPtr[e] <= headEnd;
                  base[e] <= headEnd;
               end else if (fifoRd[e]) begin
                  rPtr[e] <= rPtr[e] + 6'h01;
               end
               if (commit[e]) begin
                  wPtr[e] <= wPtr[e] + rxLen[5:0];
               end
            end
         end

         // Hardware set wins over a software clear in the same cycle.
         always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
               overrun[e] <= 1'b0;
               forceStall[e] <= 1'b0;
               dataErr[e] <= 1'b0;
            end else begin
               if (rxIn.start && rxIn.ep == 2'(e) && iso[e] && pktCnt[e] != 2'h0) begin
                  overrun[e] <= 1'b1;
               end else if (selW && !cpuReq.wdata[uoe_pkg::CSR_OVERRUN]) begin
                  overrun[e] <= 1'b0;
               end
               if (state == uoe_pkg::RX_RECV && curEp == 2'(e) && rxIn.valid
                   && overSize) begin
                  forceStall[e] <= 1'b1;
               end else if (selW && !cpuReq.wdata[uoe_pkg::CSR_FORCE_STALL]) begin
                  forceStall[e] <= 1'b0;
               end
               if (state == uoe_pkg::RX_RECV && curEp == 2'(e) && rxIn.bad && iso[e]) begin
                  dataErr[e] <= 1'b1;
               end else if (selW && !cpuReq.wdata[uoe_pkg::CSR_DATA_ERR]) begin
                  dataErr[e] <= 1'b0;
               end
            end
         end

         always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
               sendStall[e] <= 1'b0;
               iso[e] <= 1'b0;
               autoClr[e] <= 1'b0;
               inMaxp[e] <= uoe_pkg::RESET_BYTE;
               outMaxp[e] <= uoe_pkg::RESET_BYTE;
            end else begin
               if (selW) begin
                  sendStall[e] <= cpuReq.wdata[uoe_pkg::CSR_SEND_STALL];
                  iso[e] <= cpuReq.wdata[uoe_pkg::CSR_ISO];
                  autoClr[e] <= cpuReq.wdata[uoe_pkg::CSR_AUTO_CLEAR];
               end
               if (wrInMaxp && epSel == 2'(e)) begin
                  inMaxp[e] <= cpuReq.wdata;
               end
               if (wrOutMaxp && epSel == 2'(e)) begin
                  outMaxp[e] <= cpuReq.wdata;
               end
            end
         end

         uoe_byte_fifo u_tx_fifo (
            .ref_clk(ref_clk),
            .reset_n(reset_n),
            .pushValid(wrFifo && epSel == 2'(e)),
            .pushData(cpuReq.wdata),
            .pushReady(),
            .popReq(txPop && txEp == 2'(e)),
            .headData(txHead[e]),
            .empty(txEmpty[e])
         );

         sequence s_commit;
            commit[e] && !release_[e];
         endsequence
         sequence s_over;
            state == uoe_pkg::RX_RECV && curEp == 2'(e) && rxIn.valid && overSize;
         endsequence
         property p_ready_set;
            @(posedge ref_clk) disable iff (!reset_n)
               s_commit |=> (pktCnt[e] != 2'h0) && (pktCnt[e] == $past(pktCnt[e]) + 2'h1);
         endproperty
         a_ready_set: assert property (p_ready_set) else $error("ready not set");
         property p_count_load;
            @(posedge ref_clk) disable iff (!reset_n)
               (s_commit and (pktCnt[e] == 2'h0)) |=> (len0[e] == $past(rxLen));
         endproperty
         a_count_load: assert property (p_count_load) else $error("count not loaded");
         property p_auto_clear;
            @(posedge ref_clk) disable iff (!reset_n)
               (autoHit[e] && !commit[e] && pktCnt[e] == 2'h1) |=> (pktCnt[e] == 2'h0);
         endproperty
         a_auto_clear: assert property (p_auto_clear) else $error("no auto clear");
         property p_force_stall;
            @(posedge ref_clk) disable iff (!reset_n)
               s_over |=> rxStall[e] ##1 (forceStall[e] || $past(selW));
         endproperty
         a_force_stall: assert property (p_force_stall) else $error("no forced stall");
         property p_overrun;
            @(posedge ref_clk) disable iff (!reset_n)
               (rxIn.start && rxIn.ep == 2'(e) && iso[e] && pktCnt[e] != 2'h0)
               |=> overrun[e];
         endproperty
         a_overrun: assert property (p_overrun) else $error("overrun missed");
         property p_flush_older;
            @(posedge ref_clk) disable iff (!reset_n)
               (csrClr[e] && pktCnt[e] == 2'h2 && !commit[e])
               |=> (pktCnt[e] == 2'h1) && (len0[e] == $past(len1[e]));
         endproperty
         a_flush_older: assert property (p_flush_older) else $error("flush wrong");
         property p_out_max_packet_size;
            @(posedge ref_clk) disable iff (!reset_n)
               (wrOutMaxp && epSel == 2'(e)) |=> (outMaxp[e] == $past(cpuReq.wdata));
         endproperty
         a_out_max_packet_size: assert property (p_out_max_packet_size) else $error("OUT size lost");
         property p_in_max_packet_size;
            @(posedge ref_clk) disable iff (!reset_n)
               (wrInMaxp && epSel == 2'(e)) |=> (inMaxp[e] == $past(cpuReq.wdata));
         endproperty
         a_in_max_packet_size: assert property (p_in_max_packet_size) else $error("IN size lost");
         property p_read_step;
            @(posedge ref_clk) disable iff (!reset_n)
               (fifoRd[e] && !release_[e]) |=> (rPtr[e] == $past(rPtr[e]) + 6'h01);
         endproperty
         a_read_step: assert property (p_read_step) else $error("pointer step");
      end
   endgenerate

   // ======================================================
   // Endpoint select and transmit data
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         epSel <= uoe_pkg::RESET_EP;
      end else if (wrSel) begin
         epSel <= cpuReq.wdata[1:0];
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         txData <= uoe_pkg::RESET_BYTE;
      end else if (txPop && !txEmpty[txEp]) begin
         txData <= txHead[txEp];
      end
   end

   // ======================================================
   // Interrupts
   always_comb begin
      intSet = 8'h00;
      for (int i = 0; i < uoe_pkg::EP_NUM; i++) begin
         intSet[i] = commit[i];
         intSet[uoe_pkg::INT_ERR_BASE + i] =
            (rxIn.start && rxIn.ep == 2'(i) && iso[i] && pktCnt[i] != 2'h0)
            || (state == uoe_pkg::RX_RECV && curEp == 2'(i)
                && ((rxIn.valid && overSize) || (rxIn.bad && iso[i])));
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         intStatus <= uoe_pkg::RESET_BYTE;
         intEnable <= uoe_pkg::RESET_BYTE;
      end else begin
         intStatus <= intSet | (intStatus & ~(wrIntClr ? cpuReq.wdata : 8'h00));
         if (wrIntEn) begin
            intEnable <= cpuReq.wdata;
         end
      end
   end

   assign irq = |(intStatus & intEnable);

   // ======================================================
   // Read port: data stand in the cycle after the strobe.
   assign fifoByte = rxMem[epSel][rPtr[epSel][4:0]];

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cpuRdData <= uoe_pkg::RESET_BYTE;
      end else if (cpuReq.rd) begin
         case (cpuReq.addr)
            uoe_pkg::ADDR_EP_SELECT: cpuRdData <= {6'h00, epSel};
            uoe_pkg::ADDR_OUT_CSR: cpuRdData <= {autoClr[epSel], 1'b0, dataErr[epSel],
               forceStall[epSel], iso[epSel], sendStall[epSel], overrun[epSel],
               pktCnt[epSel] != 2'h0};
            uoe_pkg::ADDR_IN_MAX_PACKET_SIZE: cpuRdData <= inMaxp[epSel];
            uoe_pkg::ADDR_OUT_MAX_PACKET_SIZE: cpuRdData <= outMaxp[epSel];
            uoe_pkg::ADDR_RX_COUNT: cpuRdData <= len0[epSel];
            uoe_pkg::ADDR_FIFO_DATA: cpuRdData <= fifoByte;
            uoe_pkg::ADDR_INT_STATUS: cpuRdData <= intStatus;
            uoe_pkg::ADDR_INT_ENABLE: cpuRdData <= intEnable;
            default: cpuRdData <= uoe_pkg::RESET_BYTE;
         endcase
      end
   end

   property p_read_byte;
      @(posedge ref_clk) disable iff (!reset_n)
         rdFifo |=> (cpuRdData == $past(fifoByte));
   endproperty
   a_read_byte: assert property (p_read_byte) else $error("wrong FIFO byte");
endmodule

// ==== verif/uoe_host_model.sv ====
`timescale 1ns/1ns
module uoe_host_model (
   input wire logic ref_clk,
   input wire logic [7:0] txData,
   output uoe_pkg::uoe_rx_t rxIn,
   output logic txPop,
   output logic [1:0] txEp
);
   // ==========================================================
   // Link side
   // Outside a strobe the data and endpoint lines toggle.
   // A design that samples them late then sees garbage, not a stale value.
   initial begin
      rxIn = '0;
      txPop = 1'b0;
      txEp = 2'h0;
   end

   function automatic uoe_pkg::uoe_rx_t mk(logic st, logic va, logic [7:0] d, logic gd,
                                           logic [1:0] e);
      return '{start: st, valid: va, data: d, good: gd, bad: 1'b0, ep: e};
   endfunction

   task automatic sendPacket(input logic [1:0] ep, input logic [7:0] bytes[$]);
      @(posedge ref_clk);
      rxIn <= mk(1'b1, 1'b0, ~rxIn.data, 1'b0, ep);
      foreach (bytes[i]) begin
         @(posedge ref_clk);
         rxIn <= mk(1'b0, 1'b1, bytes[i], 1'b0, ~ep);
      end
      @(posedge ref_clk);
      rxIn <= mk(1'b0, 1'b0, ~rxIn.data, 1'b1, ~ep);
      @(posedge ref_clk);
      rxIn <= mk(1'b0, 1'b0, ~rxIn.data, 1'b0, ep);
   endtask

   task automatic popByte(input logic [1:0] ep, output logic [7:0] b);
      @(posedge ref_clk);
      txPop <= 1'b1;
      txEp <= ep;
      @(posedge ref_clk);
      txPop <= 1'b0;
      txEp <= ~ep;
      #1 b = txData;
   endtask
endmodule

// ==== verif/usb_out_endpoint_fifo_ctrl_test.sv ====
`timescale 1ns/1ns
`define CHK(got, exp) begin testsRun++; if ((got) !== (exp)) begin miscompares++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module usb_out_endpoint_fifo_ctrl_test;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   uoe_pkg::uoe_cpu_t cpuReq = '0;
   uoe_pkg::uoe_rx_t rxIn;
   logic [7:0] cpuRdData, txData, rd, b, want;
   logic [3:0] rxStall, rxRoom, txEmpty;
   logic txPop, irq;
   logic [1:0] txEp;
   int miscompares = 0;
   int testsRun = 0;
   int unsigned rng = 3619;
   logic [7:0] modelRx[4][$];
   logic [7:0] modelTx[$];
   logic [7:0] pkt[$];

   uoe_out_ep_ctrl dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .cpuReq(cpuReq),
      .cpuRdData(cpuRdData), .rxIn(rxIn), .rxStall(rxStall), .rxRoom(rxRoom),
      .txPop(txPop), .txEp(txEp), .txData(txData), .txEmpty(txEmpty), .irq(irq));
   uoe_host_model host_u (.ref_clk(ref_clk), .txData(txData), .rxIn(rxIn),
      .txPop(txPop), .txEp(txEp));

   initial begin
      forever #20 ref_clk = ~ref_clk;
   end

   // ==========================================================
   // Helpers
   function automatic logic [7:0] nextRand();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng[7:0];
   endfunction

   task automatic wrReg(input logic [9:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      cpuReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      cpuReq.wr <= 1'b0;
      #1;
   endtask

   task automatic rdReg(input logic [9:0] a);
      @(posedge ref_clk);
      cpuReq <= '{addr: a, wdata: ~cpuReq.wdata, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      cpuReq.rd <= 1'b0;
      #1 rd = cpuRdData;
   endtask

   task automatic rxPkt(input logic [1:0] ep, input int n);
      pkt.delete();
      repeat (n) begin
         pkt.push_back(nextRand());
         modelRx[ep].push_back(pkt[$]);
      end
      host_u.sendPacket(ep, pkt);
   endtask

   task automatic unload(input logic [1:0] ep, input int n);
      repeat (n) begin
         rdReg(uoe_pkg::ADDR_FIFO_DATA);
         // The macro reads its arguments twice, so the model byte is taken first.
         want = modelRx[ep].pop_front();
         `CHK(rd, want)
      end
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", testsRun, miscompares);
      if (miscompares == 0 && testsRun > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // A hang anywhere in the sequence ends here as a failure.
   initial begin
      repeat (20000) @(posedge ref_clk);
      miscompares++;
      final_report();
   end

   // ==========================================================
   // Main sequence
   initial begin
      repeat (12) @(posedge ref_clk);
      reset_n <= 1'b1;
      for (int e = 0; e < 4; e++) begin
         wrReg(uoe_pkg::ADDR_EP_SELECT, 8'(e));
         rdReg(uoe_pkg::ADDR_IN_MAX_PACKET_SIZE);
         `CHK(rd, 8'h00)
         rdReg(uoe_pkg::ADDR_OUT_MAX_PACKET_SIZE);
         `CHK(rd, 8'h00)
         rdReg(uoe_pkg::ADDR_OUT_CSR);
         `CHK(rd, 8'h00)
         rdReg(uoe_pkg::ADDR_RX_COUNT);
         `CHK(rd, 8'h00)
         b = nextRand();
         wrReg(uoe_pkg::ADDR_IN_MAX_PACKET_SIZE, b);
         rdReg(uoe_pkg::ADDR_IN_MAX_PACKET_SIZE);
         `CHK(rd, b)
         b = nextRand();
         wrReg(uoe_pkg::ADDR_OUT_MAX_PACKET_SIZE, b);
         rdReg(uoe_pkg::ADDR_OUT_MAX_PACKET_SIZE);
         `CHK(rd, b)
      end
      wrReg(10'h3FF, 8'hA5);
      rdReg(10'h3FF);
      `CHK(rd, 8'h00)
      // Full-size packet with auto clear, interrupt masked, then unmasked and cleared.
      wrReg(uoe_pkg::ADDR_EP_SELECT, 8'h01);
      wrReg(uoe_pkg::ADDR_OUT_MAX_PACKET_SIZE, 8'h08);
      wrReg(uoe_pkg::ADDR_OUT_CSR, 8'h80);
      rxPkt(2'h1, 8);
      #1 `CHK(irq, 1'b0)
      wrReg(uoe_pkg::ADDR_INT_ENABLE, 8'h02);
      `CHK(irq, 1'b1)
      rdReg(uoe_pkg::ADDR_RX_COUNT);
      `CHK(rd, 8'h08)
      rdReg(uoe_pkg::ADDR_OUT_CSR);
      `CHK(rd, 8'h81)
      unload(2'h1, rd == 8'h81 ? 8 : 0);
      rdReg(uoe_pkg::ADDR_OUT_CSR);
      `CHK(rd, 8'h80)
      wrReg(uoe_pkg::ADDR_INT_CLEAR, 8'h02);
      `CHK(irq, 1'b0)
      // Two packets held, flush the older, release the newer part-read.
      wrReg(uoe_pkg::ADDR_EP_SELECT, 8'h02);
      wrReg(uoe_pkg::ADDR_OUT_MAX_PACKET_SIZE, 8'h10);
      rxPkt(2'h2, 3);
      rxPkt(2'h2, 5);
      #1 `CHK(rxRoom[2], 1'b0)
      wrReg(uoe_pkg::ADDR_OUT_CSR, 8'h41);
      repeat (3) void'(modelRx[2].pop_front());
      rdReg(uoe_pkg::ADDR_RX_COUNT);
      `CHK(rd, 8'h05)
      rdReg(uoe_pkg::ADDR_OUT_CSR);
      `CHK(rd, 8'h01)
      unload(2'h2, 2);
      wrReg(uoe_pkg::ADDR_OUT_CSR, 8'h00);
      rdReg(uoe_pkg::ADDR_OUT_CSR);
      `CHK(rd, 8'h00)
      `CHK(rxRoom[2], 1'b1)
      // Oversize packet forces a stall until software clears it.
      wrReg(uoe_pkg::ADDR_EP_SELECT, 8'h03);
      wrReg(uoe_pkg::ADDR_OUT_MAX_PACKET_SIZE, 8'h04);
      rxPkt(2'h3, 5);
      modelRx[3].delete();
      #1 `CHK(rxStall[3], 1'b1)
      rdReg(uoe_pkg::ADDR_OUT_CSR);
      `CHK(rd, 8'h10)
      wrReg(uoe_pkg::ADDR_OUT_CSR, 8'h00);
      `CHK(rxStall[3], 1'b0)
      // A software stall answers STALL by itself, without the forced flag.
      wrReg(uoe_pkg::ADDR_OUT_CSR, 8'h04);
      `CHK(rxStall[3], 1'b1)
      wrReg(uoe_pkg::ADDR_OUT_CSR, 8'h00);
      `CHK(rxStall[3], 1'b0)
      // Isochronous token while a packet is still pending.
      wrReg(uoe_pkg::ADDR_EP_SELECT, 8'h00);
      wrReg(uoe_pkg::ADDR_OUT_MAX_PACKET_SIZE, 8'h08);
      wrReg(uoe_pkg::ADDR_OUT_CSR, 8'h08);
      rxPkt(2'h0, 2);
      rdReg(uoe_pkg::ADDR_OUT_CSR);
      `CHK(rd, 8'h09)
      rxPkt(2'h0, 2);
      rdReg(uoe_pkg::ADDR_OUT_CSR);
      `CHK(rd & 8'h0B, 8'h0B)
      wrReg(uoe_pkg::ADDR_OUT_CSR, 8'h09);
      rdReg(uoe_pkg::ADDR_OUT_CSR);
      `CHK(rd & 8'h0B, 8'h09)
      // IN bytes written by software come out in order at the link side.
      wrReg(uoe_pkg::ADDR_EP_SELECT, 8'h01);
      repeat (4) begin
         modelTx.push_back(nextRand());
         wrReg(uoe_pkg::ADDR_FIFO_DATA, modelTx[$]);
      end
      `CHK(txEmpty[1], 1'b0)
      repeat (4) begin
         host_u.popByte(2'h1, b);
         want = modelTx.pop_front();
         `CHK(b, want)
      end
      `CHK(txEmpty[1], 1'b1)
      final_report();
   end
endmodule
